// [hw/dvs_pkg.sv]
// Purpose: Shared constants and carrier types for the set-point serial slave
// Assumes: One system clock at 125 MHz samples the two bus pins
// Notes:   Slave address is a parameter with an arbitrary default
package dvs_pkg;
  localparam int          CLK_MHZ          = 125;
  localparam logic [6:0]  DVS_ADDR_DEF     = 7'h0C;   // Arbitrary default
  localparam logic [3:0]  VLEVEL_RESET     = 4'h9;    // 1.3 V
  localparam logic [1:0]  SLEW_RESET       = 2'h1;    // 10 uA source
  localparam int          VLEVEL_LSB       = 0;
  localparam int          SLEW_LSB         = 4;
  localparam logic [7:0]  SETTING_MASK     = 8'h3F;
  localparam int          MV_BASE          = 850;
  localparam int          MV_STEP          = 50;
  localparam logic [4:0]  SLEW_UA_00       = 5'h05;
  localparam logic [4:0]  SLEW_UA_01       = 5'h0A;
  localparam logic [4:0]  SLEW_UA_10       = 5'h18;
  localparam logic [4:0]  SLEW_UA_11       = 5'h1F;   // 47 uA does not fit; widened below
  localparam logic [5:0]  SLEW_UA_11_W     = 6'h2F;

  typedef struct packed {
    logic [1:0] slew_rate_field;
    logic [3:0] voltage_level_field;
  } dvs_setting_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } dvs_bus_t;
endpackage

// [hw/dvs_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module dvs_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] init_i,
  output logic      [W-1:0] clean_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dvs_sync_st_t;

  dvs_sync_st_t st_reg;
  dvs_sync_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  // Idle bus is high; reset to ones avoids a false start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{default: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign clean_o = st_reg.q;
endmodule

// [hw/dvs_slave.sv]
// Purpose: Two-wire slave holding the core voltage and slew setting byte
// Assumes: clk_i at 125 MHz, far faster than fast-mode bus clock
// Notes:   Pin mode bypasses the bus; the pins then drive code bits 0 and 1
`timescale 1ns/1ps
module dvs_slave
  import dvs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DVS_ADDR_DEF
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire dvs_pkg::dvs_bus_t     bus_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire logic                  pin_code_select_i,
  input  wire logic [1:0]            voltage_code_hi_i,
  output dvs_pkg::dvs_setting_t      setting_o,
  output logic [3:0]                 voltage_code_o,
  output logic [10:0]                ref_mv_o,
  output logic [5:0]                 slew_ua_o,
  output logic                       pin_mode_o
);
  import dvs_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK} dvs_state_t;

  typedef struct packed {
    dvs_state_t   state;
    logic [7:0]   shift;
    logic [3:0]   cnt;
    logic         sda_low;
    logic         scl_q;
    logic         sda_q;
    logic         pin_mode;
    dvs_setting_t setting;
    logic [1:0]   hi_pins;
  } dvs_st_t;

  dvs_st_t     st_reg;
  dvs_st_t     st_next;
  logic [1:0]  clean;
  logic [2:0]  hi_clean;
  logic        scl;
  logic        sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [7:0]  rd_byte;

  dvs_sync #(.W(2)) u_bus_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({bus_i.scl, bus_i.sda}),
    .init_i  (2'b11),
    .clean_o (clean)
  );

  dvs_sync #(.W(3)) u_strap_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({pin_code_select_i, voltage_code_hi_i}),
    .init_i  (3'h7),
    .clean_o (hi_clean)
  );

  assign scl       = clean[1];
  assign sda       = clean[0];
  assign scl_rise  = scl && !st_reg.scl_q;
  assign scl_fall  = !scl && st_reg.scl_q;
  assign start_det = scl && st_reg.scl_q && st_reg.sda_q && !sda;
  assign stop_det  = scl && st_reg.scl_q && !st_reg.sda_q && sda;
  assign rd_byte   = {2'b00, st_reg.setting} & SETTING_MASK;

  always_comb begin
    st_next         = st_reg;
    st_next.scl_q   = scl;
    st_next.sda_q   = sda;
    st_next.pin_mode = hi_clean[2];
    st_next.hi_pins = hi_clean[1:0];
    if (st_reg.pin_mode) begin
      st_next.state   = ST_IDLE;
      st_next.sda_low = 1'b0;
    end else if (start_det) begin
      st_next.state   = ST_ADDR;
      st_next.cnt     = 4'h0;
      st_next.sda_low = 1'b0;
    end else if (stop_det) begin
      st_next.state   = ST_IDLE;
      st_next.sda_low = 1'b0;
    end else begin
      case (st_reg.state)
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], sda};
            st_next.cnt   = st_reg.cnt + 4'h1;
          end
          if (scl_fall && st_reg.cnt == 4'h8) begin
            if (st_reg.state == ST_WDATA) begin
              st_next.state   = ST_WACK;
              st_next.sda_low = 1'b1;
            end else if (st_reg.shift[7:1] == SLAVE_ADDR) begin
              st_next.state   = ST_AACK;
              st_next.sda_low = 1'b1;
            end else begin
              st_next.state = ST_IDLE;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_rise && st_reg.state == ST_WACK) begin
            st_next.setting = dvs_setting_t'(st_reg.shift[5:0]);
          end
          if (scl_fall) begin
            st_next.cnt = 4'h0;
            if (st_reg.state == ST_AACK && st_reg.shift[0]) begin
              st_next.state   = ST_RDATA;
              st_next.shift   = rd_byte;
              st_next.sda_low = !rd_byte[7];
            end else begin
              st_next.state   = ST_WDATA;
              st_next.sda_low = 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == 4'h7) begin
              st_next.state   = ST_RACK;
              st_next.sda_low = 1'b0;
            end else begin
              st_next.shift   = {st_reg.shift[6:0], 1'b0};
              st_next.sda_low = !st_reg.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            st_next.state = ST_IDLE;
          end
        end
        default: begin
          st_next.sda_low = 1'b0;
        end
      endcase
    end
    // A strap rising mid-frame drops the frame at once, so no state outlives the bus
    if (hi_clean[2]) begin
      st_next.state   = ST_IDLE;
      st_next.sda_low = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.state   <= ST_IDLE;
      st_reg.scl_q   <= 1'b1;
      st_reg.sda_q   <= 1'b1;
      st_reg.pin_mode <= 1'b1;
      st_reg.setting <= '{slew_rate_field: SLEW_RESET, voltage_level_field: VLEVEL_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  function automatic logic [5:0] slew_ua(input logic [1:0] code);
    case (code)
      2'h0:    slew_ua = {1'b0, SLEW_UA_00};
      2'h1:    slew_ua = {1'b0, SLEW_UA_01};
      2'h2:    slew_ua = {1'b0, SLEW_UA_10};
      default: slew_ua = SLEW_UA_11_W;
    endcase
  endfunction

  // Oversampling at 125 MHz covers standard and fast rates alike
  assign sda_o          = 1'b0;
  assign sda_oe_o       = st_reg.sda_low && !st_reg.pin_mode;
  assign setting_o      = st_reg.setting;
  assign pin_mode_o     = st_reg.pin_mode;
  // Pin mode: bus pins give bits 0 and 1, strap pins bits 2 and 3
  assign voltage_code_o = st_reg.pin_mode ? {st_reg.hi_pins, st_reg.sda_q, st_reg.scl_q}
                                          : st_reg.setting.voltage_level_field;
  assign ref_mv_o       = 11'(MV_BASE) + 11'(MV_STEP) * {7'h00, voltage_code_o};
  assign slew_ua_o      = st_reg.pin_mode ? {1'b0, SLEW_UA_01}
                                          : slew_ua(st_reg.setting.slew_rate_field);

  chk_ack_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ST_AACK) |-> sda_oe_o) else $error("address ack not driven");
  chk_wack_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ST_WACK) |-> sda_oe_o) else $error("data ack not driven");
  // A zero bit is sent by pulling the line, so the two top bits must drive it
  chk_hi_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ST_RDATA && st_reg.cnt < 4'h2) |-> sda_oe_o) else $error("high bits not zero");
  chk_pin_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_mode_o |-> !sda_oe_o) else $error("bus drive in pin mode");
  // Step written as 32+16+2 so that a slip in the product above shows up
  chk_ref_map: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_mv_o == 11'(MV_BASE) + 11'({voltage_code_o, 5'h00}) + 11'({voltage_code_o, 4'h0})
                + 11'({voltage_code_o, 1'b0})) else $error("ref map wrong");
  chk_latch_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ST_WACK && scl_rise && !start_det && !stop_det && !st_reg.pin_mode)
      |=> setting_o == dvs_setting_t'($past(st_reg.shift[5:0]))) else $error("write not latched");
  chk_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_det && !st_reg.pin_mode) |=> !sda_oe_o) else $error("drive after stop");
  chk_hold_setting: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state != ST_WACK) |=> $stable(setting_o)) else $error("setting changed outside ack");
endmodule

// [sim/dvs_host_model.sv]
// Purpose: Bus master model driving the set-point slave pins
// Assumes: Data line has a pull-up; the slave only pulls it low
// Notes:   q is a quarter bit in clocks: 78 fast rate, 313 standard
`timescale 1ns/1ps
module dvs_host_model
  import dvs_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         sda_oe_i,
  input  wire logic         sda_i,
  output dvs_pkg::dvs_bus_t bus_o
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  int   q     = 78;
  // Slave pulls the line to its driven level; released data shows the master's level sda_m
  assign bus_o = {scl_m, sda_oe_i ? sda_i : sda_m};
  task automatic wt();
    repeat (q) @(posedge clk_i);
  endtask
  task automatic start();
    wt();
    sda_m <= 1'b1;
    wt();
    scl_m <= 1'b1;
    wt();
    sda_m <= 1'b0;
    wt();
    scl_m <= 1'b0;
  endtask
  task automatic stop();
    wt();
    sda_m <= 1'b0;
    wt();
    scl_m <= 1'b1;
    wt();
    sda_m <= 1'b1;
    wt();
  endtask
  // Data moves mid-low; the wire is sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    wt();
    sda_m <= b;
    wt();
    scl_m <= 1'b1;
    wt();
    r = bus_o.sda;
    wt();
    scl_m <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic a9, output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(a9, ak);
  endtask
endmodule

// [sim/dvs_slave_bench.sv]
// Purpose: Self-checking bench for the set-point serial slave
// Assumes: 125 MHz clock; the host model plays bus master
// Notes:   Each test but reset and pin control is a bus call followed by port checks
`timescale 1ns/1ps
module dvs_slave_bench;
  import dvs_pkg::*;
  localparam logic [6:0] ADDR = DVS_ADDR_DEF;
  logic         clk_i             = 1'b0;
  logic         rst_i             = 1'b1;
  logic         pin_code_select_i = 1'b0;
  logic [1:0]   voltage_code_hi_i = 2'h0;
  dvs_bus_t     bus;
  logic         sda_oe;
  logic         sda_drv;
  dvs_setting_t setting;
  logic [3:0]   vcode;
  logic [10:0]  ref_mv;
  logic [5:0]   slew_ua;
  logic         pin_mode;
  logic [7:0]   rx;
  logic         ak;
  int           n_mismatch        = 0;
  int           checked           = 0;
  int           ua [4]            = '{5, 10, 24, 47};
  logic [3:0]   lv [4]            = '{4'h0, 4'hF, 4'h5, 4'hA};
  dvs_slave #(.SLAVE_ADDR(ADDR)) u_dvs_slave (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .sda_o(sda_drv), .sda_oe_o(sda_oe),
    .pin_code_select_i(pin_code_select_i), .voltage_code_hi_i(voltage_code_hi_i),
    .setting_o(setting), .voltage_code_o(vcode), .ref_mv_o(ref_mv), .slew_ua_o(slew_ua),
    .pin_mode_o(pin_mode));
  dvs_host_model u_dvs_host_model (.clk_i(clk_i), .sda_oe_i(sda_oe), .sda_i(sda_drv), .bus_o(bus));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
    logic k;
    u_dvs_host_model.start();
    u_dvs_host_model.xfer({a, 1'b0}, 1'b1, rx, ak);
    for (int i = 0; i < n; i++) begin
      u_dvs_host_model.xfer(i == 0 ? d0 : d1, 1'b1, rx, k);
      cmp(k, 1'b0, "data ack");
    end
    u_dvs_host_model.stop();
  endtask
  task automatic rd();
    logic k;
    u_dvs_host_model.start();
    u_dvs_host_model.xfer({ADDR, 1'b1}, 1'b1, rx, ak);
    cmp(ak, 1'b0, "read address ack");
    u_dvs_host_model.xfer(8'hFF, 1'b1, rx, k);
    u_dvs_host_model.stop();
  endtask
  task automatic state(input logic [5:0] s, input string t);
    cmp(setting, s, "setting");
    cmp(vcode, s[3:0], "code");
    cmp(ref_mv, 850 + 50 * s[3:0], "millivolts");
    cmp(slew_ua, ua[s[5:4]], "slew");
    $display("Test %s finished", t);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp(pin_mode, 1'b0, "strap");
    state(6'h19, "reset");
    rd();
    cmp(rx, 8'h19, "read default");
    // Bits 7:6 are set on purpose; they must not land
    for (int i = 0; i < 4; i++) begin
      wr(ADDR, {2'b11, i[1:0], lv[i]}, 8'h00, 1);
      cmp(ak, 1'b0, "address ack");
      state({i[1:0], lv[i]}, "codes");
    end
    rd();
    cmp(rx, 8'h3A, "read back");
    wr(ADDR, 8'h03, 8'hEC, 2);
    state(6'h2C, "two bytes");
    wr(ADDR ^ 7'h01, 8'h00, 8'h00, 0);
    cmp(ak, 1'b1, "foreign address");
    state(6'h2C, "foreign address");
    // Write, then a repeated start straight into a read of the same byte
    u_dvs_host_model.start();
    u_dvs_host_model.xfer({ADDR, 1'b0}, 1'b1, rx, ak);
    cmp(ak, 1'b0, "address ack before restart");
    u_dvs_host_model.xfer(8'h05, 1'b1, rx, ak);
    cmp(ak, 1'b0, "data ack before restart");
    u_dvs_host_model.start();
    u_dvs_host_model.xfer({ADDR, 1'b1}, 1'b1, rx, ak);
    cmp(ak, 1'b0, "read ack after restart");
    u_dvs_host_model.xfer(8'hFF, 1'b1, rx, ak);
    u_dvs_host_model.stop();
    cmp(rx, 8'h05, "read after restart");
    state(6'h05, "repeated start");
    u_dvs_host_model.q = 313;
    wr(ADDR, 8'h17, 8'h00, 1);
    state(6'h17, "standard rate");
    @(posedge clk_i);
    pin_code_select_i <= 1'b1;
    voltage_code_hi_i <= 2'b01;
    u_dvs_host_model.scl_m <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp(vcode, 4'h6, "pin code");
    cmp(slew_ua, 6'h0A, "pin slew");
    cmp(setting, 6'h17, "setting kept");
    $display("Test pin control finished");
    print_verdict();
  end
  initial begin
    repeat (98000) @(posedge clk_i);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
